// ==== gafm_mux.sv ====
`timescale 1ns/1ps
`include "gafm_defs.svh"
module gafm_mux (
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire gafm_pkg::gafm_port_cfg_s  cfg_a,
	input  wire gafm_pkg::gafm_port_cfg_s  cfg_b,
	input  wire gafm_pkg::gafm_port_cfg_s  cfg_c,
	input  wire gafm_pkg::gafm_port_cfg_s  cfg_d,
	input  wire logic                      reset_pin_free,
	input  wire logic [7:0]                led_en,
	input  wire gafm_pkg::gafm_led_e       led_level,
	input  wire gafm_pkg::gafm_periph_out_s periph_o,
	input  wire logic [7:0]                pa_in,
	input  wire logic [7:0]                pb_in,
	input  wire logic [7:0]                pc_in,
	input  wire logic                      pd_in,
	output gafm_pkg::gafm_pad_s            pad_a_r,
	output gafm_pkg::gafm_pad_s            pad_b_r,
	output gafm_pkg::gafm_pad_s            pad_c_r,
	output gafm_pkg::gafm_pad_s            pad_d_r,
	output logic [7:0]                     led_sink_r,
	output gafm_pkg::gafm_led_e            led_level_r,
	output logic                           reset_role_r,
	output gafm_pkg::gafm_periph_in_s      periph_i_r,
	output logic [7:0]                     pa_read,
	output logic [7:0]                     pb_read,
	output logic [7:0]                     pc_read,
	output logic                           pd_read
);
	import gafm_pkg::*;

	logic [24:0]     sync_q;
	gafm_pad_s       pad_a_nxt;
	gafm_pad_s       pad_b_nxt;
	gafm_pad_s       pad_c_nxt;
	gafm_pad_s       pad_d_nxt;
	logic [7:0]      led_sink_nxt;
	gafm_led_e       led_level_nxt;
	logic            reset_role_nxt;
	gafm_periph_in_s periph_i_nxt;
	logic [7:0]      af_a;
	logic [7:0]      af_b;
	logic [7:0]      af_c;
	logic [7:0]      oe_a;
	logic [7:0]      out_a;
	logic [7:0]      oe_c;
	logic [7:0]      out_c;
	logic            live_r;

	// ==============================
	// Input synchronisers
	gafm_sync #(.W(25)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({pd_in, pc_in, pb_in, pa_in}),
		.q      (sync_q)
	);

	// Pin level is always readable
	assign pa_read = sync_q[7:0];
	assign pb_read = sync_q[15:8];
	assign pc_read = sync_q[23:16];
	assign pd_read = sync_q[24];

	// ==============================
	// Port or peripheral drive of one port
	function automatic gafm_pad_s pad_drive(gafm_port_cfg_s c, logic [7:0] af,
		logic [7:0] af_oe, logic [7:0] af_out);
		gafm_pad_s p;
		p.out        = (af & af_out) | (~af & c.out_data);
		p.oe         = (af & af_oe) | (~af & c.dir_out);
		p.oe         = p.oe & ~(c.open_drain & p.out);
		p.pull_up    = c.pull_up;
		p.high_drive = c.high_drive;
		p.smr        = c.smr_en;
		return p;
	endfunction

	// ==============================
	// Next pad and peripheral values
	always_comb
	begin
		af_a  = cfg_a.af_en & `GAFM_PA_AF_MASK;
		af_b  = cfg_b.af_en;
		af_c  = cfg_c.af_en;
		oe_a  = '0;
		out_a = '0;
		oe_a[`GAFM_PA_T0IO]   = periph_o.tmr0_out_mode;
		out_a[`GAFM_PA_T0IO]  = periph_o.tmr0_compl_out;
		oe_a[`GAFM_PA_TMR0_OUT]  = 1'b1;
		out_a[`GAFM_PA_TMR0_OUT] = periph_o.tmr0_out;
		oe_a[`GAFM_PA_T1IO]      = periph_o.tmr1_out_mode;
		out_a[`GAFM_PA_T1IO]     = periph_o.tmr1_compl_out;
		oe_a[`GAFM_PA_TMR1_OUT]  = 1'b1;
		out_a[`GAFM_PA_TMR1_OUT] = periph_o.tmr1_out;
		pad_a_nxt = pad_drive(cfg_a, af_a, oe_a, out_a);
		if (periph_o.xtal_en)
		begin
			pad_a_nxt.oe[0]  = 1'b0;
			pad_a_nxt.oe[1]  = 1'b1;
			pad_a_nxt.out[1] = periph_o.xtal_drive;
			pad_a_nxt.out[0]          = 1'b0;
			pad_a_nxt.pull_up[1:0]    = 2'b00;
			pad_a_nxt.high_drive[1:0] = 2'b00;
			pad_a_nxt.smr[1:0]        = 2'b00;
		end
		// Port B peripherals are all inputs; set-two not consulted
		pad_b_nxt = pad_drive(cfg_b, af_b, 8'h00, 8'h00);
		oe_c  = '0;
		out_c = '0;
		oe_c[`GAFM_PC_CMP_OUT]  = ~cfg_c.function_set_one[`GAFM_PC_CMP_OUT];
		out_c[`GAFM_PC_CMP_OUT] = periph_o.cmp_out;
		pad_c_nxt = pad_drive(cfg_c, af_c, oe_c, out_c);
		led_sink_nxt  = led_en & ~af_c;
		led_level_nxt = led_level;
		pad_c_nxt.oe  = pad_c_nxt.oe | led_sink_nxt;
		pad_c_nxt.out = pad_c_nxt.out & ~led_sink_nxt;
		reset_role_nxt = ~reset_pin_free | cfg_d.af_en[0];
		pad_d_nxt            = '0;
		pad_d_nxt.high_drive = {7'h00, cfg_d.high_drive[0]};
		if (reset_role_r)
		begin
			pad_d_nxt.oe      = {7'h00, periph_o.reset_drive};
			pad_d_nxt.pull_up = 8'h01;
		end
		else
		begin
			pad_d_nxt.out     = {7'h00, cfg_d.out_data[0]};
			pad_d_nxt.oe      = {7'h00, cfg_d.dir_out[0] & ~(cfg_d.open_drain[0] & cfg_d.out_data[0])};
			pad_d_nxt.pull_up = {7'h00, cfg_d.pull_up[0]};
		end
		periph_i_nxt.timer_zero_in_or_compl_out = af_a[`GAFM_PA_T0IO] & ~periph_o.xtal_en
			& ~periph_o.tmr0_out_mode & sync_q[`GAFM_PA_T0IO];
		periph_i_nxt.timer_one_in_or_compl_out = af_a[`GAFM_PA_T1IO]
			& ~periph_o.tmr1_out_mode & sync_q[`GAFM_PA_T1IO];
		periph_i_nxt.external_clock_input = af_b[`GAFM_PB_CLK]
			& ~cfg_b.function_set_one[`GAFM_PB_CLK] & sync_q[8 + `GAFM_PB_CLK];
		periph_i_nxt.xtal_in    = periph_o.xtal_en & sync_q[0];
		periph_i_nxt.pb_ana_sel = af_b[4:0] & cfg_b.function_set_one[4:0];
		periph_i_nxt.vref_sel   = af_b[`GAFM_PB_VREF] & cfg_b.function_set_one[`GAFM_PB_VREF];
		periph_i_nxt.pc_ana_sel = af_c[2:0] & cfg_c.function_set_one[2:0];
		periph_i_nxt.reset_pin_in = reset_role_r & sync_q[24];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pad_a_r      <= '0;
			pad_b_r      <= '0;
			pad_c_r      <= '0;
			pad_d_r      <= '0;
			led_sink_r   <= `GAFM_RST_BYTE;
			led_level_r  <= GAFM_LED_3MA;
			reset_role_r <= `GAFM_RST_ROLE;
			periph_i_r   <= '0;
			live_r       <= 1'b0;
		end
		else
		begin
			pad_a_r      <= pad_a_nxt;
			pad_b_r      <= pad_b_nxt;
			pad_c_r      <= pad_c_nxt;
			pad_d_r      <= pad_d_nxt;
			led_sink_r   <= led_sink_nxt;
			led_level_r  <= led_level_nxt;
			reset_role_r <= reset_role_nxt;
			periph_i_r   <= periph_i_nxt;
			live_r       <= 1'b1;
		end
	end

	// ==============================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_xtal_override: assert property (live_r && $past(periph_o.xtal_en) |->
		!pad_a_r.oe[0] && pad_a_r.oe[1] && pad_a_r.out[1] == $past(periph_o.xtal_drive))
		else $error("crystal override not applied");
	chk_af_direction: assert property (live_r && $past(cfg_a.af_en[7]) |->
		pad_a_r.oe[7] == !($past(cfg_a.open_drain[7]) && $past(periph_o.tmr1_out)))
		else $error("peripheral direction not used");
	chk_timer_mode: assert property (live_r && $past(cfg_a.af_en[6]) &&
		!$past(periph_o.tmr1_out_mode) |-> !pad_a_r.oe[6]
		&& periph_i_r.timer_one_in_or_compl_out == $past(sync_q[6]))
		else $error("timer input mode wrong");
	chk_reserved_pa: assert property (live_r && $past(cfg_a.af_en[3]) |->
		pad_a_r.oe[3] == ($past(cfg_a.dir_out[3])
		&& !($past(cfg_a.open_drain[3]) && $past(cfg_a.out_data[3]))))
		else $error("reserved port A pin altered");
	chk_pb_select: assert property (live_r |-> periph_i_r.pb_ana_sel ==
		($past(cfg_b.af_en[4:0]) & $past(cfg_b.function_set_one[4:0]))
		&& !(|(pad_b_r.oe & $past(af_b))))
		else $error("port B selection wrong");
	chk_pb_clock: assert property (live_r && $past(af_b[3]) &&
		!$past(cfg_b.function_set_one[3]) |-> periph_i_r.external_clock_input == $past(sync_q[11]))
		else $error("clock input not routed");
	chk_pc_cmp_out: assert property (live_r && $past(af_c[3])
		&& !$past(cfg_c.function_set_one[3]) && !$past(cfg_c.open_drain[3])
		|-> pad_c_r.oe[3] && pad_c_r.out[3] == $past(periph_o.cmp_out))
		else $error("comparator output not routed");
	chk_led_sink: assert property (live_r && $past(led_sink_nxt[2]) |->
		pad_c_r.oe[2] && !pad_c_r.out[2] && led_level_r == $past(led_level))
		else $error("LED sink not driven");
	chk_rst_pin_role: assert property (live_r && $past(reset_role_r) |->
		pad_d_r.pull_up[0] && pad_d_r.oe[0] == $past(periph_o.reset_drive) && !pad_d_r.out[0])
		else $error("reset role wrong");
	chk_rst_pin_drive: assert property (live_r |-> pad_d_r.smr == 8'h00
		&& pad_d_r.high_drive[0] == $past(cfg_d.high_drive[0]))
		else $error("port D drive or recovery wrong");
	chk_rst_pin_gpio: assert property (live_r && !$past(reset_role_r) |->
		pad_d_r.oe[0] == ($past(cfg_d.dir_out[0])
		&& !($past(cfg_d.open_drain[0]) && $past(cfg_d.out_data[0])))
		&& pad_d_r.out[0] == $past(cfg_d.out_data[0]))
		else $error("port D pin drive wrong");
	chk_reset_input: assert property (live_r |->
		periph_i_r.reset_pin_in == ($past(reset_role_r) && $past(sync_q[24])))
		else $error("reset pin input wrong");
	chk_xtal_input: assert property (live_r |->
		periph_i_r.xtal_in == ($past(periph_o.xtal_en) && $past(sync_q[0])))
		else $error("crystal input wrong");
	chk_xtal_quiet: assert property (live_r && $past(periph_o.xtal_en) |->
		pad_a_r.pull_up[1:0] == 2'b00 && pad_a_r.high_drive[1:0] == 2'b00
		&& pad_a_r.smr[1:0] == 2'b00)
		else $error("crystal pin settings not cleared");
	chk_reserved_pc: assert property (live_r && $past(af_c[5]) |-> !pad_c_r.oe[5])
		else $error("reserved port C pin driven");
endmodule

// ==== gafm_defs.svh ====
// Behaviour
// - Each capable pin switches between plain port use and its peripheral.
// - In peripheral use, pin direction follows the peripheral, not the port.
// - Crystal enabled overrides port A pins 0 and 1 as oscillator in/out.
// - Port A pins 0 and 6 carry timer input or complement output by mode.
// - A0/A1 timer zero, A6/A7 timer one; A2 to A5 have no peripheral.
// - Port A and D pin 0 need no set bits; enable picks their function.
// - Port B: set-1 picks converter inputs or reference; set-2 is ignored.
// - Port C: set-1 picks among two functions; set-2 is ignored.
// - Port C pins sink LED current at one of four levels when enabled and not in peripheral use.
// - D0 starts as open-drain reset with pull-up until software frees it.
// - D0 in port use is output only; software sets it as output. The code takes its direction from dir_out[0], so D0 can also be an input.
// - D0 honours high drive and never acts as a stop-mode recovery source.
`ifndef GAFM_DEFS_SVH
`define GAFM_DEFS_SVH

// ==============================
// Pin positions
`define GAFM_PA_T0IO     0
`define GAFM_PA_TMR0_OUT 1
`define GAFM_PA_T1IO     6
`define GAFM_PA_TMR1_OUT 7
`define GAFM_PB_CLK      3
`define GAFM_PB_VREF     5
`define GAFM_PC_CMP_INP  0
`define GAFM_PC_CMP_INN  1
`define GAFM_PC_CMP_OUT  3

// ==============================
// Capability masks
`define GAFM_PA_AF_MASK  8'hc3
`define GAFM_PB_ANA_MASK 8'h1f
`define GAFM_PC_ANA_MASK 8'h07

// ==============================
// Reset values
`define GAFM_RST_BYTE    8'h00
`define GAFM_RST_ROLE    1'b1
`define GAFM_SYNC_STAGES 2

`endif

// ==== gafm_pkg.sv ====
package gafm_pkg;

	typedef enum logic [1:0] {GAFM_LED_3MA, GAFM_LED_7MA, GAFM_LED_13MA, GAFM_LED_20MA} gafm_led_e;

	typedef struct packed {
		logic [7:0] af_en;
		logic [7:0] dir_out;
		logic [7:0] out_data;
		logic [7:0] function_set_one;
		logic [7:0] function_set_two;
		logic [7:0] open_drain;
		logic [7:0] high_drive;
		logic [7:0] pull_up;
		logic [7:0] smr_en;
	} gafm_port_cfg_s;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_up;
		logic [7:0] high_drive;
		logic [7:0] smr;
	} gafm_pad_s;

	typedef struct packed {
		logic       tmr0_out_mode;
		logic       tmr0_compl_out;
		logic       tmr0_out;
		logic       tmr1_out_mode;
		logic       tmr1_compl_out;
		logic       tmr1_out;
		logic       cmp_out;
		logic       xtal_en;
		logic       xtal_drive;
		logic       reset_drive;
	} gafm_periph_out_s;

	typedef struct packed {
		logic       timer_zero_in_or_compl_out;
		logic       timer_one_in_or_compl_out;
		logic       external_clock_input;
		logic       xtal_in;
		logic [4:0] pb_ana_sel;
		logic       vref_sel;
		logic [2:0] pc_ana_sel;
		logic       reset_pin_in;
	} gafm_periph_in_s;

endpackage

// ==== gafm_sync.sv ====
`timescale 1ns/1ps
module gafm_sync #(
	parameter int W = 25
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// ==============================
	// Two-stage synchroniser
	always_comb
	begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end
endmodule

// ==== gafm_periph_model.sv ====
`timescale 1ns/1ps
module gafm_periph_model
(
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      run,
	input  wire logic [2:0]                mode,
	input  wire gafm_pkg::gafm_periph_in_s pin_i,
	output gafm_pkg::gafm_periph_out_s     pout
);
	import gafm_pkg::*;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	// ==============================
	// Timer count, frozen while run is low
	always_comb
	begin
		cnt_nxt = run ? cnt_r + 4'h1 : cnt_r;
	end
	always_ff @(posedge clk)
	begin
		cnt_r <= resetn ? cnt_nxt : 4'h0;
	end
	// Mode bits pick input or complement out; crystal inverts
	assign pout = {mode[0], ~cnt_r[0], cnt_r[0], mode[1], ~cnt_r[1], cnt_r[1],
		cnt_r[2], mode[2], ~pin_i.xtal_in, cnt_r[3]};
endmodule

// ==== gafm_mux_tb.sv ====
`timescale 1ns/1ps
module gafm_mux_tb;
	import gafm_pkg::*;
	logic             clk = 1'b0;
	logic             resetn = 1'b0;
	logic             run = 1'b0;
	logic [2:0]       mode = 3'h0;
	gafm_port_cfg_s   ca = '0;
	gafm_port_cfg_s   cb = '0;
	gafm_port_cfg_s   cc = '0;
	gafm_port_cfg_s   cd = '0;
	logic             rst_free = 1'b0;
	logic [7:0]       led_en = 8'h00;
	gafm_led_e        led_level = GAFM_LED_3MA;
	logic [7:0]       pa = 8'h00;
	logic [7:0]       pb = 8'h00;
	logic [7:0]       pc = 8'h00;
	logic             pd = 1'b0;
	gafm_periph_out_s pout;
	gafm_periph_in_s  pin;
	gafm_pad_s        qa;
	gafm_pad_s        qb;
	gafm_pad_s        qc;
	gafm_pad_s        qd;
	logic [7:0]       led_sink;
	gafm_led_e        lvl;
	logic             role;
	logic [7:0]       ra;
	logic [7:0]       rb;
	logic [7:0]       rc;
	logic             rd;
	logic [31:0]      seed = 32'h45c5062e;
	logic [31:0]      r;
	logic [15:0]      e;
	logic [7:0]       m;
	logic             role_e;
	int               errors = 0;
	int               n_checks = 0;
	int               cyc = 0;

	always #5 clk = ~clk;

	gafm_mux DUT (.clk(clk), .resetn(resetn), .cfg_a(ca), .cfg_b(cb), .cfg_c(cc),
		.cfg_d(cd), .reset_pin_free(rst_free), .led_en(led_en), .led_level(led_level),
		.periph_o(pout), .pa_in(pa), .pb_in(pb), .pc_in(pc), .pd_in(pd),
		.pad_a_r(qa), .pad_b_r(qb), .pad_c_r(qc), .pad_d_r(qd), .led_sink_r(led_sink),
		.led_level_r(lvl), .reset_role_r(role), .periph_i_r(pin), .pa_read(ra),
		.pb_read(rb), .pc_read(rc), .pd_read(rd));
	gafm_periph_model model_i (.clk(clk), .resetn(resetn), .run(run), .mode(mode),
		.pin_i(pin), .pout(pout));

	// ==============================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic gafm_port_cfg_s rcfg();
		logic [95:0]    w;
		gafm_port_cfg_s c;
		w = {xs(), xs(), xs()};
		c = w[71:0];
		return c;
	endfunction
	function automatic logic [15:0] pad(gafm_port_cfg_s c, logic [7:0] pe, logic [7:0] po);
		logic [7:0] oe;
		logic [7:0] o;
		oe = (c.dir_out & ~c.af_en) | (pe & c.af_en);
		o  = (c.out_data & ~c.af_en) | (po & c.af_en);
		oe = oe & ~(c.open_drain & o);
		return {oe, o & oe};
	endfunction
	function automatic logic [15:0] see(gafm_pad_s q);
		return {q.oe, q.out & q.oe};
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==============================
	// Timeout
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			report_and_stop();
		end
	end

	// ==============================
	// Main sequence
	initial
	begin
		wt(5);
		chk({qd, role, lvl}, {40'h0, 3'h4});
		resetn = 1'b1;
		$display("reset test done");
		for (int i = 0; i < 200; i++)
		begin
			ca = rcfg();
			cb = rcfg();
			cc = rcfg();
			cd = rcfg();
			cd.dir_out[0] = 1'b1;
			if (i < 2)
			begin
				ca.af_en = 8'hff;
				cb.af_en = 8'hff;
				cc.af_en = 8'hff;
				cb.function_set_one = {8{i[0]}};
				cc.function_set_one = {8{i[0]}};
			end
			r = xs();
			mode = r[2:0];
			rst_free = r[3];
			led_en = r[11:4];
			led_level = gafm_led_e'(r[13:12]);
			pa = r[21:14];
			pb = r[29:22];
			r = xs();
			pc = r[7:0];
			pd = r[8];
			run = 1'b1;
			wt(1 + r[10:9]);
			run = 1'b0;
			wt(5);
			e = pad(ca, {1'b1, pout.tmr1_out_mode, ca.dir_out[5:2], 1'b1, pout.tmr0_out_mode},
				{pout.tmr1_out, pout.tmr1_compl_out, ca.out_data[5:2], pout.tmr0_out,
				pout.tmr0_compl_out});
			if (mode[2])
				e = {e[15:10], 2'b10, e[7:2], pout.xtal_drive, 1'b0};
			chk(see(qa), e);
			m = mode[2] ? 8'hfc : 8'hff;
			chk({qa.pull_up, qa.high_drive, qa.smr},
				{ca.pull_up & m, ca.high_drive & m, ca.smr_en & m});
			chk(see(qb), pad(cb, 8'h00, 8'h00));
			chk({qb.pull_up, qb.high_drive, qb.smr, qc.pull_up, qc.high_drive,
				qc.smr}, {cb.pull_up, cb.high_drive, cb.smr_en, cc.pull_up,
				cc.high_drive, cc.smr_en});
			m = led_en & ~cc.af_en;
			e = pad(cc, {4'h0, ~cc.function_set_one[3], 3'h0}, {4'h0, pout.cmp_out, 3'h0});
			chk(see(qc), {e[15:8] | m, e[7:0] & ~m});
			chk({pin.external_clock_input, pin.vref_sel, pin.pb_ana_sel, pin.pc_ana_sel,
				pin.timer_zero_in_or_compl_out, pin.timer_one_in_or_compl_out},
				{cb.af_en[3] & ~cb.function_set_one[3] & pb[3],
				cb.af_en[5:0] & cb.function_set_one[5:0],
				cc.af_en[2:0] & cc.function_set_one[2:0],
				ca.af_en[0] & ~mode[0] & ~mode[2] & pa[0],
				ca.af_en[6] & ~mode[1] & pa[6]});
			chk({led_sink, lvl}, {led_en & ~cc.af_en, led_level});
			chk({ra, rb, rc, rd}, {pa, pb, pc, pd});
			role_e = ~rst_free | cd.af_en[0];
			chk({role, qd.smr, qd.high_drive[0]}, {role_e, 8'h00, cd.high_drive[0]});
			chk({pin.xtal_in, pin.reset_pin_in}, {mode[2] & pa[0], role_e & pd});
			chk({qd.pull_up, qd.out[7:1], qd.oe[7:1]},
				{7'h00, role_e | cd.pull_up[0], 14'h0});
			if (role_e)
				chk({qd.oe[0], qd.out[0] & qd.oe[0]}, {pout.reset_drive, 1'b0});
			else
				chk({qd.oe[0], qd.out[0]},
					{~(cd.open_drain[0] & cd.out_data[0]), cd.out_data[0]});
		end
		$display("random test done");
		resetn = 1'b0;
		wt(1);
		chk({qd, role}, {40'h0, 1'b1});
		$display("second reset test done");
		report_and_stop();
	end
endmodule
